// ===== design/tppwm_pkg.sv
package tppwm_pkg;

  // ==========================================================
  // widths
  localparam int TPPWM_AW = 3;
  localparam int TPPWM_DW = 16;
  localparam int TPPWM_DEAD_W = 10;
  localparam int TPPWM_MASK_W = 9;
  localparam int TPPWM_CNT_W = 17;

  // ==========================================================
  // register indices
  localparam logic [2:0] TPPWM_ADDR_CONTROL = 3'h0;
  localparam logic [2:0] TPPWM_ADDR_STATUS = 3'h1;
  localparam logic [2:0] TPPWM_ADDR_HALF_PERIOD = 3'h2;
  localparam logic [2:0] TPPWM_ADDR_DEAD_TIME = 3'h3;
  localparam logic [2:0] TPPWM_ADDR_DUTY_A = 3'h4;
  localparam logic [2:0] TPPWM_ADDR_DUTY_B = 3'h5;
  localparam logic [2:0] TPPWM_ADDR_DUTY_C = 3'h6;
  localparam logic [2:0] TPPWM_ADDR_MASK = 3'h7;

  // ==========================================================
  // field positions and reset values
  localparam int TPPWM_MODE_BIT = 2;
  localparam int TPPWM_HALF_BIT = 0;
  localparam logic [3:0] TPPWM_ALL_WRITTEN = 4'hf;
  localparam int TPPWM_WR_PERIOD = 0;
  localparam int TPPWM_WR_DUTY_A = 1;
  localparam int TPPWM_WR_DUTY_B = 2;
  localparam int TPPWM_WR_DUTY_C = 3;
  localparam logic [15:0] TPPWM_PERIOD_RST = 16'h0000;
  localparam logic [9:0] TPPWM_DEAD_RST = 10'h000;
  localparam logic [15:0] TPPWM_DUTY_RST = 16'h0000;
  localparam logic [8:0] TPPWM_MASK_RST = 9'h000;
  localparam int TPPWM_A_HI = 5;
  localparam int TPPWM_A_LO = 4;
  localparam int TPPWM_B_HI = 3;
  localparam int TPPWM_B_LO = 2;
  localparam int TPPWM_C_HI = 1;
  localparam int TPPWM_C_LO = 0;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    TPPWM_IDLE,
    TPPWM_PRESTART,
    TPPWM_HOLD,
    TPPWM_RUN
  } tppwm_phase_e;

  typedef struct packed {
    logic wr;
    logic [2:0] addr;
    logic [15:0] wdata;
  } tppwm_bus_s;

  typedef struct packed {
    logic [15:0] period;
    logic [9:0] dead;
    logic [15:0] duty_a;
    logic [15:0] duty_b;
    logic [15:0] duty_c;
    logic [8:0] mask;
  } tppwm_timing_s;

  typedef struct packed {
    tppwm_phase_e phase;
    logic half;
    logic [16:0] cnt;
    logic mode_double;
    logic [3:0] written;
    tppwm_timing_s stage;
    tppwm_timing_s act;
    logic sync;
    logic [5:0] gate;
    logic [15:0] rdata;
  } tppwm_state_s;

endpackage : tppwm_pkg

// ===== design/tppwm_timing_unit.sv
module tppwm_timing_unit
  import tppwm_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // register port
  input wire tppwm_bus_s reg_req_in,
  output logic [15:0] reg_rdata_out,
  // gate drive outputs
  output logic phase_a_high_out,
  output logic phase_a_low_out,
  output logic phase_b_high_out,
  output logic phase_b_low_out,
  output logic phase_c_high_out,
  output logic phase_c_low_out,
  // to output control stage and processor
  output logic [8:0] output_mask_out,
  output logic period_sync_pulse_out,
  output logic irq_req_out
);

  // ==========================================================
  // pair compare
  // signed math so out-of-range thresholds clamp to 0% or 100%
  function automatic logic [1:0] tppwm_pair(
    input logic [16:0] t,
    input logic half,
    input logic [15:0] period,
    input logic [9:0] dead,
    input logic [15:0] duty
  );
    logic signed [19:0] tt;
    logic signed [19:0] hp;
    logic signed [19:0] d;
    logic signed [19:0] dt;
    logic hi;
    logic lo;
    tt = signed'({3'h0, t});
    hp = signed'({5'h00, period[15:1]});
    d = signed'({4'h0, duty});
    dt = signed'({10'h000, dead});
    if (!half) begin
      hi = (tt >= hp - d + dt);
      lo = (tt < hp - d - dt);
    end else begin
      hi = (tt < hp + d - dt);
      lo = (tt >= hp + d + dt);
    end
    return {hi, lo};
  endfunction

  function automatic logic [16:0] tppwm_last(input logic [15:0] period);
    return {1'b0, period} - 17'h00001;
  endfunction

  // ==========================================================
  // state
  tppwm_state_s st_q;
  tppwm_state_s st_d;

  always_comb begin
    logic do_sync;
    do_sync = 1'b0;
    st_d = st_q;
    st_d.sync = 1'b0;

    // register writes land in staging copies, except the control mode bit, which takes effect at once
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        TPPWM_ADDR_CONTROL: begin
          st_d.mode_double = reg_req_in.wdata[TPPWM_MODE_BIT];
        end
        TPPWM_ADDR_HALF_PERIOD: begin
          st_d.stage.period = reg_req_in.wdata;
          st_d.written[TPPWM_WR_PERIOD] = 1'b1;
          if (st_q.phase == TPPWM_IDLE) begin
            st_d.phase = TPPWM_PRESTART;
            if (st_q.mode_double) begin
              st_d.cnt = tppwm_last(reg_req_in.wdata);
            end else begin
              st_d.cnt = tppwm_last(reg_req_in.wdata)
                         + {2'h0, reg_req_in.wdata[15:1]};
            end
          end
        end
        TPPWM_ADDR_DEAD_TIME: begin
          st_d.stage.dead = reg_req_in.wdata[TPPWM_DEAD_W-1:0];
        end
        TPPWM_ADDR_DUTY_A: begin
          st_d.stage.duty_a = reg_req_in.wdata;
          st_d.written[TPPWM_WR_DUTY_A] = 1'b1;
        end
        TPPWM_ADDR_DUTY_B: begin
          st_d.stage.duty_b = reg_req_in.wdata;
          st_d.written[TPPWM_WR_DUTY_B] = 1'b1;
        end
        TPPWM_ADDR_DUTY_C: begin
          st_d.stage.duty_c = reg_req_in.wdata;
          st_d.written[TPPWM_WR_DUTY_C] = 1'b1;
        end
        TPPWM_ADDR_MASK: begin
          st_d.stage.mask = reg_req_in.wdata[TPPWM_MASK_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // ==========================================================
    // timer
    case (st_q.phase)
      TPPWM_IDLE: begin
      end
      TPPWM_PRESTART: begin
        if (st_q.cnt == '0) begin
          if (st_d.written == TPPWM_ALL_WRITTEN) begin
            do_sync = 1'b1;
          end else begin
            st_d.phase = TPPWM_HOLD;
          end
        end else begin
          st_d.cnt = st_q.cnt - 17'h00001;
        end
      end
      TPPWM_HOLD: begin
        if (st_d.written == TPPWM_ALL_WRITTEN) begin
          do_sync = 1'b1;
        end
      end
      TPPWM_RUN: begin
        if (st_q.cnt == tppwm_last(st_q.act.period)) begin
          st_d.cnt = '0;
          st_d.half = ~st_q.half;
          if (st_q.half || st_q.mode_double) begin
            do_sync = 1'b1;
          end
        end else begin
          st_d.cnt = st_q.cnt + 17'h00001;
        end
      end
      default: begin
        st_d.phase = TPPWM_IDLE;
      end
    endcase

    // a sync edge opens a new half: staged values go live here only
    if (do_sync) begin
      st_d.sync = 1'b1;
      st_d.act = st_d.stage;
      if (st_q.phase != TPPWM_RUN) begin
        st_d.phase = TPPWM_RUN;
        st_d.half = 1'b0;
        st_d.cnt = '0;
      end
    end

    // one cycle behind the counter, identical for all pairs
    if (st_q.phase == TPPWM_RUN) begin
      st_d.gate = {
        tppwm_pair(st_q.cnt, st_q.half, st_q.act.period, st_q.act.dead, st_q.act.duty_a),
        tppwm_pair(st_q.cnt, st_q.half, st_q.act.period, st_q.act.dead, st_q.act.duty_b),
        tppwm_pair(st_q.cnt, st_q.half, st_q.act.period, st_q.act.dead, st_q.act.duty_c)
      };
    end else begin
      st_d.gate = '0;
    end

    // ==========================================================
    // read back, one cycle after the address
    case (reg_req_in.addr)
      TPPWM_ADDR_CONTROL: begin
        st_d.rdata = '0;
        st_d.rdata[TPPWM_MODE_BIT] = st_q.mode_double;
      end
      TPPWM_ADDR_STATUS: begin
        st_d.rdata = '0;
        st_d.rdata[TPPWM_HALF_BIT] = st_q.half;
      end
      TPPWM_ADDR_HALF_PERIOD: st_d.rdata = st_q.stage.period;
      TPPWM_ADDR_DEAD_TIME: st_d.rdata = {6'h00, st_q.stage.dead};
      TPPWM_ADDR_DUTY_A: st_d.rdata = st_q.stage.duty_a;
      TPPWM_ADDR_DUTY_B: st_d.rdata = st_q.stage.duty_b;
      TPPWM_ADDR_DUTY_C: st_d.rdata = st_q.stage.duty_c;
      TPPWM_ADDR_MASK: st_d.rdata = {7'h00, st_q.stage.mask};
      default: st_d.rdata = '0;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q.phase <= TPPWM_IDLE;
      st_q.half <= 1'b0;
      st_q.cnt <= '0;
      st_q.mode_double <= 1'b0;
      st_q.written <= '0;
      st_q.stage <= {TPPWM_PERIOD_RST, TPPWM_DEAD_RST, TPPWM_DUTY_RST,
                     TPPWM_DUTY_RST, TPPWM_DUTY_RST, TPPWM_MASK_RST};
      st_q.act <= {TPPWM_PERIOD_RST, TPPWM_DEAD_RST, TPPWM_DUTY_RST,
                   TPPWM_DUTY_RST, TPPWM_DUTY_RST, TPPWM_MASK_RST};
      st_q.sync <= 1'b0;
      st_q.gate <= '0;
      st_q.rdata <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign reg_rdata_out = st_q.rdata;
  assign phase_a_high_out = st_q.gate[TPPWM_A_HI];
  assign phase_a_low_out = st_q.gate[TPPWM_A_LO];
  assign phase_b_high_out = st_q.gate[TPPWM_B_HI];
  assign phase_b_low_out = st_q.gate[TPPWM_B_LO];
  assign phase_c_high_out = st_q.gate[TPPWM_C_HI];
  assign phase_c_low_out = st_q.gate[TPPWM_C_LO];
  assign output_mask_out = st_q.act.mask;
  assign period_sync_pulse_out = st_q.sync;
  assign irq_req_out = st_q.sync;

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_half_end;
    st_q.phase == TPPWM_RUN && st_q.cnt == tppwm_last(st_q.act.period);
  endsequence

  sequence s_mid_end;
    s_half_end ##0 !st_q.half;
  endsequence

  property p_irq_on_sync;
    period_sync_pulse_out |-> irq_req_out;
  endproperty
  a_irq_on_sync: assert property (p_irq_on_sync)
    else $error("irq request missing on sync");

  property p_no_overlap;
    !(phase_a_high_out && phase_a_low_out) && !(phase_b_high_out && phase_b_low_out)
      && !(phase_c_high_out && phase_c_low_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both switches of a pair on");

  property p_halted_off;
    st_q.phase != TPPWM_RUN |=> st_q.gate == '0;
  endproperty
  a_halted_off: assert property (p_halted_off)
    else $error("output active while halted");

  property p_single_no_mid;
    s_mid_end ##0 !st_q.mode_double |=> !st_q.sync && st_q.half;
  endproperty
  a_single_no_mid: assert property (p_single_no_mid)
    else $error("mid sync in single update mode");

  property p_double_mid;
    s_mid_end ##0 st_q.mode_double |=> st_q.sync && st_q.half;
  endproperty
  a_double_mid: assert property (p_double_mid)
    else $error("mid sync missing in double update mode");

  property p_load_at_sync;
    st_q.sync |-> st_q.act == st_q.stage;
  endproperty
  a_load_at_sync: assert property (p_load_at_sync)
    else $error("live values differ from staged at sync");

  property p_mask_only_at_sync;
    $changed(output_mask_out) |-> period_sync_pulse_out;
  endproperty
  a_mask_only_at_sync: assert property (p_mask_only_at_sync)
    else $error("mask changed away from sync");

  property p_start_count;
    reg_req_in.wr && reg_req_in.addr == TPPWM_ADDR_HALF_PERIOD
      && st_q.phase == TPPWM_IDLE && !st_q.mode_double
      |=> st_q.phase == TPPWM_PRESTART
          && st_q.cnt == tppwm_last($past(reg_req_in.wdata))
                         + {2'h0, $past(reg_req_in.wdata[15:1])};
  endproperty
  a_start_count: assert property (p_start_count)
    else $error("startup delay not one and a half periods");

  property p_status_second_half;
    s_mid_end |=> st_q.half ##1 (st_q.half || st_q.sync);
  endproperty
  a_status_second_half: assert property (p_status_second_half)
    else $error("half status not set after midpoint");

  // the very first period write arms the start count
  sequence s_period_start;
    reg_req_in.wr && reg_req_in.addr == TPPWM_ADDR_HALF_PERIOD && st_q.phase == TPPWM_IDLE;
  endsequence

  property p_start_count_dbl;
    s_period_start ##0 st_q.mode_double
      |=> st_q.phase == TPPWM_PRESTART
          && st_q.cnt == tppwm_last($past(reg_req_in.wdata));
  endproperty
  a_start_count_dbl: assert property (p_start_count_dbl)
    else $error("startup delay not one period in double mode");

  property p_halted_until_written;
    st_q.written != TPPWM_ALL_WRITTEN |-> st_q.phase != TPPWM_RUN && st_q.gate == '0;
  endproperty
  a_halted_until_written: assert property (p_halted_until_written)
    else $error("timer running before all values written");

  property p_sync_single_cycle;
    st_q.sync |=> !st_q.sync;
  endproperty
  a_sync_single_cycle: assert property (p_sync_single_cycle)
    else $error("sync pulse longer than one cycle");

  property p_period_end_sync;
    s_half_end ##0 st_q.half |=> st_q.sync && !st_q.half;
  endproperty
  a_period_end_sync: assert property (p_period_end_sync)
    else $error("no sync at period start");

  // gates lag the counter, so the check lands one cycle later
  property p_zero_dead_complement;
    st_q.phase == TPPWM_RUN && st_q.act.dead == '0
      |=> phase_a_low_out == !phase_a_high_out && phase_b_low_out == !phase_b_high_out
          && phase_c_low_out == !phase_c_high_out;
  endproperty
  a_zero_dead_complement: assert property (p_zero_dead_complement)
    else $error("gap between complements with zero dead time");

  property p_act_steady;
    !st_q.sync |-> $stable(st_q.act);
  endproperty
  a_act_steady: assert property (p_act_steady)
    else $error("live values changed inside a half period");

  // a duty past period plus dead time pins the pair fully high
  property p_clamp_full;
    st_q.phase == TPPWM_RUN
      && {1'b0, st_q.act.duty_a} >= {1'b0, st_q.act.period} + {7'h00, st_q.act.dead}
      |=> phase_a_high_out && !phase_a_low_out;
  endproperty
  a_clamp_full: assert property (p_clamp_full)
    else $error("duty above range not clamped to full on");

endmodule // tppwm_timing_unit

// ===== sim/tppwm_gate_model.sv
module tppwm_gate_model
  import tppwm_pkg::*;
(
  // clock and window control
  input wire logic clk_in,
  input wire logic clr_in,
  // gate commands, bit order as the timing unit indices
  input wire logic [5:0] gate_in,
  // per-gate on-time in core clocks, pair overlap flag
  output logic [5:0][15:0] on_cnt_out,
  output logic shoot_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // on-time accumulators, cleared at the start of a window
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 6; i++) begin
      on_cnt_out[i] <= clr_in ? 16'h0000 : on_cnt_out[i] + {15'h0000, gate_in[i]};
    end
  end

  // ==========================================================
  // a pair conducting together would short the dc link
  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      shoot_out <= 1'b0;
    end else if ((gate_in[5] & gate_in[4]) | (gate_in[3] & gate_in[2]) |
                 (gate_in[1] & gate_in[0])) begin
      shoot_out <= 1'b1;
    end
  end
endmodule // tppwm_gate_model

// ===== sim/tppwm_timing_unit_tb_top.sv
module tppwm_timing_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tppwm_pkg::*;

  // half period, never 0 or 1
  localparam int P = 40;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  tppwm_bus_s req = '0;
  logic [15:0] rdata;
  logic [5:0] gate;
  logic [8:0] mask;
  logic sync, irq, shoot;
  logic clr = 1'b1;
  logic rd_arm = 1'b0;
  logic [5:0][15:0] cnt;
  logic [15:0] dty [3];
  logic [15:0] dt;
  logic [15:0] sync_q [$];
  logic [15:0] rd_q [$];
  int cyc = 0, n_fail = 0, cmp_count = 0, n_sync = 0, c0, pc, s;
  integer seed = 32'h9475;

  always #20 core_clk_in = ~core_clk_in;

  tppwm_timing_unit dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .phase_a_high_out(gate[TPPWM_A_HI]), .phase_a_low_out(gate[TPPWM_A_LO]),
    .phase_b_high_out(gate[TPPWM_B_HI]), .phase_b_low_out(gate[TPPWM_B_LO]),
    .phase_c_high_out(gate[TPPWM_C_HI]), .phase_c_low_out(gate[TPPWM_C_LO]),
    .output_mask_out(mask), .period_sync_pulse_out(sync), .irq_req_out(irq));

  tppwm_gate_model drv (
    .clk_in(core_clk_in), .clr_in(clr), .gate_in(gate), .on_cnt_out(cnt), .shoot_out(shoot));

  // ==========================================================
  // checking
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic int clampv(input int v);
    return (v < 0) ? 0 : ((v > P) ? P : v);
  endfunction

  always @(posedge core_clk_in) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      results();
    end
  end

  // read data lands one edge after the address
  always @(posedge core_clk_in) begin
    if (rd_arm) begin
      #1 chk(rdata, rd_q.pop_front(), "read");
      rd_arm <= 1'b0;
    end
  end

  always @(negedge core_clk_in) begin
    if (sync === 1'b1) begin
      n_sync++;
      chk({15'h0000, irq}, 16'h0001, "irq");
      if (sync_q.size() > 0) chk(cyc[15:0], sync_q.pop_front(), "sync time");
    end
  end

  // ==========================================================
  // register port and sequencing
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge core_clk_in);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge core_clk_in);
    #1 c0 = cyc;
    @(negedge core_clk_in);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(negedge core_clk_in);
    req.addr <= a;
    rd_q.push_back(e);
    rd_arm <= 1'b1;
    @(negedge core_clk_in);
  endtask

  task automatic wait_sync();
    repeat (4 * P + 8) begin
      @(negedge core_clk_in);
      if (sync === 1'b1) break;
    end
    chk({15'h0000, sync}, 16'h0001, "sync seen");
    s = cyc;
  endtask

  task automatic boot(input int gap, input logic dbl);
    rst_in <= 1'b1;
    repeat (6) @(negedge core_clk_in);
    rst_in <= 1'b0;
    n_sync = 0;
    for (int a = 0; a < 8; a++) rd(a[2:0], 16'h0000);
    if (dbl) wr(TPPWM_ADDR_CONTROL, 16'h0004);
    wr(TPPWM_ADDR_MASK, 16'h00a7);
    wr(TPPWM_ADDR_HALF_PERIOD, P[15:0]);
    pc = c0;
    wr(TPPWM_ADDR_DUTY_A, 16'h0004);
    wr(TPPWM_ADDR_DUTY_B, 16'h0004);
    repeat (gap) @(negedge core_clk_in);
    chk(16'(n_sync), 16'h0000, "early sync");
    chk({1'b0, mask, gate}, 16'h0000, "idle outputs");
    // noted before the write: a held start syncs on the edge that takes it
    if (gap != 0) sync_q.push_back(16'(cyc + 2));
    else if (dbl) sync_q.push_back(16'(pc + P));
    else sync_q.push_back(16'(pc + P * 3 / 2));
    wr(TPPWM_ADDR_DUTY_C, 16'h0004);
    wait_sync();
  endtask

  initial begin
    boot(2 * P, 1'b0);
    boot(0, 1'b1);
    boot(0, 1'b0);
    repeat (2) @(negedge core_clk_in);
    chk({7'h00, mask}, 16'h00a7, "mask");
    sync_q.push_back(16'(s + 2 * P));
    rd(TPPWM_ADDR_STATUS, 16'h0000);
    repeat (P) @(negedge core_clk_in);
    rd(TPPWM_ADDR_STATUS, 16'h0001);
    // zero dead time, random, then a duty past the clamp
    for (int k = 0; k < 3; k++) begin
      dt = (k == 0) ? 16'h0000 : 16'($random(seed) & 7);
      for (int i = 0; i < 3; i++) dty[i] = 16'($random(seed) & 15);
      if (k == 2) dty[0] = 16'h0100;
      wr(TPPWM_ADDR_DEAD_TIME, dt);
      for (int i = 0; i < 3; i++) wr(3'(TPPWM_ADDR_DUTY_A + i), dty[i]);
      wait_sync();
      wait_sync();
      clr <= 1'b1;
      @(negedge core_clk_in);
      clr <= 1'b0;
      repeat (2 * P) @(negedge core_clk_in);
      for (int i = 0; i < 3; i++) begin
        chk(cnt[5 - 2 * i], 16'(2 * (P - clampv(P / 2 - int'(dty[i]) + int'(dt))))
            , "high on-time");
        chk(cnt[4 - 2 * i], 16'(2 * clampv(P / 2 - int'(dty[i]) - int'(dt)))
            , "low on-time");
      end
      chk({15'h0000, shoot}, 16'h0000, "overlap");
    end
    wait_sync();
    wr(TPPWM_ADDR_CONTROL, 16'h0004);
    sync_q.push_back(16'(s + P));
    sync_q.push_back(16'(s + 2 * P));
    wait_sync();
    rd(TPPWM_ADDR_STATUS, 16'h0001);
    wait_sync();
    rd(TPPWM_ADDR_STATUS, 16'h0000);
    rd(TPPWM_ADDR_CONTROL, 16'h0004);
    rd(TPPWM_ADDR_HALF_PERIOD, P[15:0]);
    rd(TPPWM_ADDR_DEAD_TIME, dt);
    repeat (2) @(negedge core_clk_in);
    chk(16'(sync_q.size()), 16'h0000, "missed sync");
    results();
  end
endmodule // tppwm_timing_unit_tb_top
